/* File: rtl/ndjb_pkg.sv */
// Shared constants, types and helpers of the network dejitter buffer
package ndjb_pkg;
	// Packet geometry
	localparam int PKT_LEN = 188;
	localparam logic [7:0] LAST_IDX = 8'(PKT_LEN - 1);
	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int STC_HZ = 5_000_000;
	localparam int JITTER_US = 400;
	localparam int RMAX_BPS = 20_000_000;
	localparam logic [31:0] HALF_J_TICKS = 32'(JITTER_US * (STC_HZ / 1_000_000) / 2);
	// Sizing: J times peak rate, then integrated total
	localparam int DEJITTER_BUFFER_SIZE = JITTER_US * (RMAX_BPS / 1_000_000) / 8;
	localparam int STD_BUF_BYTES = 512;
	localparam int INTEG_BUF_BYTES = STD_BUF_BYTES + 512 + DEJITTER_BUFFER_SIZE;
	localparam int BUF_BYTES = 2048;
	localparam int AW = 11;
	localparam int TAG_DEPTH = 8;
	localparam int TW = 3;
	localparam logic [AW:0] FREE_LIM = 12'(BUF_BYTES - PKT_LEN);
	localparam logic [AW:0] HALF_FILL = 12'(BUF_BYTES / 2);
	// Loop words: stc step and drain pacing as fractions of mclk
	localparam logic [15:0] FREQ_NOM = 16'h8000;
	localparam logic [15:0] FREQ_MIN = 16'h7000;
	localparam logic [15:0] FREQ_MAX = 16'h9000;
	localparam logic [15:0] RATE_NOM = 16'h4000;
	localparam logic [15:0] RATE_MIN = 16'h0100;
	localparam logic [15:0] RATE_MAX = 16'hff00;

	typedef enum logic [1:0] {
		MODE_CBR = 2'h0,
		MODE_TSTAMP = 2'h1,
		MODE_NETCLK = 2'h3,
		MODE_INTEG = 2'h2
	} ndjb_mode_type;

	typedef enum logic {
		ST_IDLE = 1'h0,
		ST_SEND = 1'h1
	} ndjb_state_type;

	typedef struct packed {
		logic valid;
		logic sop;
		logic strip;
		logic pcr_flag;
		logic [12:0] pid;
		logic [7:0] data;
		logic [31:0] cr;
	} ndjb_in_type;

	typedef struct packed {
		logic valid;
		logic sop;
		logic [7:0] data;
	} ndjb_out_type;

	// True once now has reached mark, modulo wrap
	function automatic logic ndjb_reached(input logic [31:0] now, input logic [31:0] mark);
		logic [31:0] d;
		d = now - mark;
		return !d[31];
	endfunction
endpackage

/* File: rtl/ndjb_top.sv */
// Network dejitter buffer with timestamp release and integrated decoder mode
//
// Overview of operation
// - Constant rate: drop network bytes, FIFO them, pace output to keep half full
// - Clock reference sample is captured when its packet enters, not on readout
// - Sender time clock is rebuilt from captured samples by a loop
// - In timestamp and network clock modes, first packet leaves when delayed clock reaches its reference sample
// - In timestamp and network clock modes, each later packet leaves when delayed clock reaches its reference sample
// - Buffer holds at least jitter bound times peak stream rate
// - Nominal delay half full, late J/2 empty, early J/2 full
// - With a common network clock, time base follows that clock
// - Integrated mode keeps only packets of the selected PID
// - Integrated mode feeds selected PID PCRs straight into the clock loop
// - Only whole packets are placed in the buffer
// - Access unit decodes when its stamp equals clock minus J/2
// - Integrated buffer covers decoder, mux, overhead, 512 bytes and jitter
module ndjb_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Configuration
	input wire ndjb_pkg::ndjb_mode_type mode,
	input wire logic [12:0] sel_pid,
	input wire logic net_tick,
	// Network side
	input wire ndjb_pkg::ndjb_in_type in_pkt,
	// Decoder side
	output ndjb_pkg::ndjb_out_type out_pkt,
	// Access unit timing
	input wire logic au_load,
	input wire logic [31:0] au_ts,
	output logic au_decode,
	// Status
	output logic locked,
	output logic [11:0] fill
);
	import ndjb_pkg::*;

	logic [7:0] mem [BUF_BYTES];
	logic [31:0] tag_mem [TAG_DEPTH];

	// Write group
	logic [AW:0] wptr_reg, wptr_next;
	logic [AW:0] spos_reg, spos_next;
	logic [AW:0] wa;
	logic [7:0] idx_reg, idx_next;
	logic acc_reg, acc_next;
	logic [31:0] ccr_reg, ccr_next;
	logic [TW-1:0] twp_reg, twp_next;
	logic byte_in, keep, room, wr_en, tag_push;

	// Clock group
	logic lock_reg, lock_next;
	logic [31:0] stc_reg, stc_next;
	logic [15:0] phase_reg, phase_next;
	logic [15:0] freq_reg, freq_next;
	logic carry, adv, feed;
	logic [31:0] delayed_time_clock;

	// Read group
	ndjb_state_type state_reg, state_next;
	logic [AW:0] rptr_reg, rptr_next;
	logic [7:0] ridx_reg, ridx_next;
	logic [TW-1:0] trp_reg, trp_next;
	logic [TW:0] tcnt_reg, tcnt_next;
	logic [15:0] pace_reg, pace_next;
	logic [15:0] rate_reg, rate_next;
	ndjb_out_type out_reg, out_next;
	logic pcar, rd_en, pop;
	logic [AW:0] count;

	// Access unit group
	logic [31:0] aut_reg, aut_next;
	logic aup_reg, aup_next;
	logic aud_reg, aud_next;

	assign count = wptr_reg - rptr_reg;
	assign fill = count;
	assign locked = lock_reg;
	assign out_pkt = out_reg;
	assign au_decode = aud_reg;

	always_comb begin
		byte_in = in_pkt.valid && !in_pkt.strip;
		keep = (mode != MODE_INTEG) || (in_pkt.pid == sel_pid);
		wptr_next = wptr_reg;
		spos_next = spos_reg;
		idx_next = idx_reg;
		acc_next = acc_reg;
		ccr_next = ccr_reg;
		twp_next = twp_reg;
		tag_push = 1'b0;
		wa = (in_pkt.sop && acc_reg) ? spos_reg : wptr_reg;
		room = ((wa - rptr_reg) <= FREE_LIM)
			&& (mode == MODE_CBR || tcnt_reg < (TW + 1)'(TAG_DEPTH));
		wr_en = byte_in && (in_pkt.sop ? (keep && room) : acc_reg);
		if (byte_in && in_pkt.sop) begin
			ccr_next = in_pkt.cr;
			acc_next = keep && room;
			spos_next = wa;
			// refused start still drops a partial
			wptr_next = wa;
		end
		if (wr_en) begin
			wptr_next = wa + 1'b1;
			idx_next = in_pkt.sop ? 8'h01 : idx_reg + 8'h01;
			if (!in_pkt.sop && idx_reg == LAST_IDX) begin
				acc_next = 1'b0;
				tag_push = (mode != MODE_CBR);
				twp_next = twp_reg + (TW)'(mode != MODE_CBR);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wptr_reg <= '0;
			spos_reg <= '0;
			idx_reg <= 8'h00;
			acc_reg <= 1'b0;
			ccr_reg <= 32'h0;
			twp_reg <= '0;
		end else begin
			wptr_reg <= wptr_next;
			spos_reg <= spos_next;
			idx_reg <= idx_next;
			acc_reg <= acc_next;
			ccr_reg <= ccr_next;
			twp_reg <= twp_next;
		end
	end

	// Storage is not reset; pointers alone define contents
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[wa[AW-1:0]] <= in_pkt.data;
		end
		if (tag_push) begin
			tag_mem[twp_reg] <= ccr_reg;
		end
	end

	always_comb begin
		// every packet start steers the loop in timestamp and network clock modes; in integrated mode only selected PID PCRs do
		feed = byte_in && in_pkt.sop
			&& (mode == MODE_TSTAMP || mode == MODE_NETCLK
			|| (mode == MODE_INTEG && in_pkt.pid == sel_pid && in_pkt.pcr_flag));
		{carry, phase_next} = {1'b0, phase_reg} + {1'b0, freq_reg};
		// common network clock drives the time base
		adv = (mode == MODE_NETCLK) ? net_tick : carry;
		stc_next = stc_reg + {31'h0, adv};
		lock_next = lock_reg;
		freq_next = freq_reg;
		// load then steer the rebuilt clock
		if (feed) begin
			if (!lock_reg) begin
				stc_next = in_pkt.cr;
				lock_next = 1'b1;
			end else if (ndjb_reached(stc_reg, in_pkt.cr)) begin
				if (freq_reg > FREQ_MIN) freq_next = freq_reg - 16'h0001;
			end else if (freq_reg < FREQ_MAX) begin
				freq_next = freq_reg + 16'h0001;
			end
		end
		// delay by half the jitter bound
		delayed_time_clock = stc_reg - HALF_J_TICKS;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			lock_reg <= 1'b0;
			stc_reg <= 32'h0;
			phase_reg <= 16'h0000;
			freq_reg <= FREQ_NOM;
		end else begin
			lock_reg <= lock_next;
			stc_reg <= stc_next;
			phase_reg <= phase_next;
			freq_reg <= freq_next;
		end
	end

	always_comb begin
		state_next = state_reg;
		rptr_next = rptr_reg;
		ridx_next = ridx_reg;
		trp_next = trp_reg;
		rate_next = rate_reg;
		rd_en = 1'b0;
		pop = 1'b0;
		{pcar, pace_next} = {1'b0, pace_reg} + {1'b0, rate_reg};
		if (mode == MODE_CBR) begin
			state_next = ST_IDLE;
			// pace output to hold the FIFO half full
			if (pcar) begin
				rd_en = (count != '0);
				if (count > HALF_FILL) begin
					if (rate_reg < RATE_MAX) rate_next = rate_reg + 16'h0001;
				end else if (rate_reg > RATE_MIN) begin
					rate_next = rate_reg - 16'h0001;
				end
			end
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					// outside integrated mode each packet waits for its own sample
					if (tcnt_reg != '0 && lock_reg
						&& (mode == MODE_INTEG || ndjb_reached(delayed_time_clock, tag_mem[trp_reg]))) begin
						state_next = ST_SEND;
					end
				end
				ST_SEND: begin
					rd_en = 1'b1;
					ridx_next = ridx_reg + 8'h01;
					if (ridx_reg == LAST_IDX) begin
						pop = 1'b1;
						ridx_next = 8'h00;
						trp_next = trp_reg + 1'b1;
						state_next = ST_IDLE;
					end
				end
			endcase
		end
		if (rd_en) rptr_next = rptr_reg + 1'b1;
		tcnt_next = tcnt_reg + (TW + 1)'(tag_push) - (TW + 1)'(pop);
		out_next.valid = rd_en;
		out_next.sop = rd_en && mode != MODE_CBR && ridx_reg == 8'h00;
		out_next.data = mem[rptr_reg[AW-1:0]];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			rptr_reg <= '0;
			ridx_reg <= 8'h00;
			trp_reg <= '0;
			tcnt_reg <= '0;
			pace_reg <= 16'h0000;
			rate_reg <= RATE_NOM;
			out_reg <= '0;
		end else begin
			state_reg <= state_next;
			rptr_reg <= rptr_next;
			ridx_reg <= ridx_next;
			trp_reg <= trp_next;
			tcnt_reg <= tcnt_next;
			pace_reg <= pace_next;
			rate_reg <= rate_next;
			out_reg <= out_next;
		end
	end

	always_comb begin
		aut_next = aut_reg;
		aup_next = aup_reg;
		aud_next = 1'b0;
		if (aup_reg && lock_reg && aut_reg == delayed_time_clock) begin
			aud_next = 1'b1;
			aup_next = 1'b0;
		end
		// A new stamp replaces a pending one
		if (au_load) begin
			aut_next = au_ts;
			aup_next = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			aut_reg <= 32'h0;
			aup_reg <= 1'b0;
			aud_reg <= 1'b0;
		end else begin
			aut_reg <= aut_next;
			aup_reg <= aup_next;
			aud_reg <= aud_next;
		end
	end

	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (rst);

	a_release_locked: assert property (
		out_pkt.sop |-> lock_reg)
		else $error("packet left before clock load");

	a_reset_empty: assert property (
		$fell(rst) |-> fill == 12'h000 && !lock_reg && !out_pkt.valid)
		else $error("not empty after reset");

	a_first_load: assert property (
		!lock_reg && feed |=> lock_reg && stc_reg == $past(in_pkt.cr))
		else $error("clock not loaded from sample");

	a_release_time: assert property (
		state_reg == ST_IDLE && state_next == ST_SEND && mode != MODE_INTEG
		|-> ndjb_reached(delayed_time_clock, tag_mem[trp_reg]))
		else $error("packet released early");

	a_packet_burst: assert property (
		out_pkt.sop |=> out_pkt.valid [*8])
		else $error("packet burst broken");

	a_strip_bytes: assert property (
		in_pkt.valid && in_pkt.strip && !rd_en |=> fill == $past(fill))
		else $error("network byte stored");

	a_pid_filter: assert property (
		byte_in && in_pkt.sop && mode == MODE_INTEG && in_pkt.pid != sel_pid
		|=> fill <= $past(fill))
		else $error("wrong PID stored");

	a_whole_packet: assert property (
		tag_push |-> acc_reg && idx_reg == LAST_IDX && (wptr_reg - spos_reg) == 12'(PKT_LEN - 1))
		else $error("partial packet tagged");

	a_au_time: assert property (
		au_decode |-> $past(aut_reg) == $past(stc_reg) - HALF_J_TICKS)
		else $error("access unit decoded off time");
endmodule

/* File: bench/ndjb_enc.sv */
// Upstream network encoder model: stamps, wraps and sends stream packets
module ndjb_enc (
	// Clock
	input wire logic mclk,
	// Network side
	output ndjb_pkg::ndjb_in_type pkt
);
	timeunit 1ns;
	timeprecision 1ns;
	import ndjb_pkg::*;
	logic [31:0] send_clock_reg = 32'h0010_0000;
	logic half_reg = 1'b0;
	initial pkt = '0;
	// sender time clock at 5 MHz
	always @(posedge mclk) begin
		half_reg <= ~half_reg;
		send_clock_reg <= send_clock_reg + 32'(half_reg);
	end
	task automatic send(input logic [12:0] pid, input logic pcr, input int len,
			output logic [31:0] stamp);
		int i;
		// network header bytes wrapped in front of the packet
		for (i = 0; i < 4; i++) begin
			@(negedge mclk);
			pkt <= '{valid: 1'b1, strip: 1'b1, data: 8'(8'ha5 + i), default: '0};
		end
		for (i = 0; i < len; i++) begin
			@(negedge mclk);
			// stamp taken as the packet departs
			if (i == 0) begin
				stamp = send_clock_reg;
			end
			pkt <= '{valid: 1'b1, sop: (i == 0), strip: 1'b0, pcr_flag: pcr, pid: pid,
				data: 8'(i), cr: stamp};
		end
		@(negedge mclk);
		// Released line shows the inverse so a stale byte never looks valid
		pkt <= '{valid: 1'b0, data: ~pkt.data, default: '0};
	endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench of the network dejitter buffer
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import ndjb_pkg::*;
	typedef struct {
		ndjb_mode_type m;
		logic [12:0] pid;
		logic pcr;
		logic tick;
		logic ev;
		logic es;
		logic [11:0] ef;
		logic lk;
	} ndjb_row_type;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic net_tick = 1'b0;
	logic tick_en = 1'b0;
	logic au_load = 1'b0;
	logic [31:0] au_ts = '0;
	logic [12:0] sel_pid = 13'h0042;
	ndjb_mode_type mode = MODE_TSTAMP;
	ndjb_in_type in_pkt;
	ndjb_out_type out_pkt;
	logic au_decode;
	logic locked;
	logic [11:0] fill;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	int bytes = 0;
	int au_n = 0;
	int au_at = 0;
	int sop_at[$];
	logic [7:0] exp_b = '0;
	logic [31:0] stamp_a;
	logic [31:0] stamp_b;
	int t0;
	int t1;
	int gap;
	// Stamped packets, selected pid with and without clock samples, other pid, network clock with and without ticks, constant rate
	ndjb_row_type rows[7] = '{
		'{MODE_TSTAMP, 13'h0005, 1'b0, 1'b0, 1'b1, 1'b1, 12'h000, 1'b1},
		'{MODE_INTEG, 13'h0042, 1'b1, 1'b0, 1'b1, 1'b1, 12'h000, 1'b1},
		'{MODE_INTEG, 13'h0043, 1'b1, 1'b0, 1'b0, 1'b0, 12'h000, 1'b0},
		'{MODE_INTEG, 13'h0042, 1'b0, 1'b0, 1'b0, 1'b0, 12'h0bc, 1'b0},
		'{MODE_NETCLK, 13'h0005, 1'b0, 1'b1, 1'b1, 1'b1, 12'h000, 1'b1},
		'{MODE_NETCLK, 13'h0005, 1'b0, 1'b0, 1'b0, 1'b0, 12'h0bc, 1'b1},
		'{MODE_CBR, 13'h0005, 1'b0, 1'b0, 1'b1, 1'b0, 12'h000, 1'b0}};

	ndjb_enc enc (.mclk(mclk), .pkt(in_pkt));
	ndjb_top dut (.mclk(mclk), .rst(rst), .mode(mode), .sel_pid(sel_pid), .net_tick(net_tick),
		.in_pkt(in_pkt), .out_pkt(out_pkt), .au_load(au_load), .au_ts(au_ts),
		.au_decode(au_decode), .locked(locked), .fill(fill));

	always #50 mclk = ~mclk;
	always @(negedge mclk) net_tick <= tick_en & ~net_tick;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (au_decode === 1'b1) begin
			au_n++;
			au_at = cyc;
		end
		if (out_pkt.valid === 1'b1) begin
			if (out_pkt.sop === 1'b1) begin
				sop_at.push_back(cyc);
				exp_b = '0;
			end
			check(out_pkt.data, exp_b);
			exp_b++;
			bytes++;
		end
	end

	task automatic do_reset(input ndjb_mode_type m);
		@(negedge mclk);
		rst = 1'b1;
		mode = m;
		tick_en = 1'b0;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		sop_at.delete();
		bytes = 0;
		exp_b = '0;
		au_n = 0;
	endtask

	initial begin
		repeat (40000) @(posedge mclk);
		errors++;
		stop_test();
	end

	initial begin
		foreach (rows[k]) begin
			do_reset(rows[k].m);
			check(fill, 12'h000);
			check(locked, 1'b0);
			tick_en = rows[k].tick;
			enc.send(rows[k].pid, rows[k].pcr, PKT_LEN, stamp_a);
			repeat (2600) @(negedge mclk);
			check(bytes != 0, rows[k].ev);
			check(sop_at.size(), rows[k].es);
			check(fill, rows[k].ef);
			check(locked, rows[k].lk);
		end
		// Partial packet cut by a new start is dropped whole
		do_reset(MODE_NETCLK);
		enc.send(13'h0005, 1'b0, 100, stamp_a);
		enc.send(13'h0005, 1'b0, PKT_LEN, stamp_b);
		@(negedge mclk);
		check(fill, 12'h0bc);
		// A refused start of another pid also drops the partial packet
		do_reset(MODE_INTEG);
		enc.send(13'h0042, 1'b1, 100, stamp_a);
		enc.send(13'h0043, 1'b1, PKT_LEN, stamp_b);
		@(negedge mclk);
		check(fill, 12'h000);
		// Eight held packets fill the tag queue; a ninth is refused whole
		do_reset(MODE_NETCLK);
		repeat (9) enc.send(13'h0005, 1'b0, PKT_LEN, stamp_b);
		check(fill, 12'(8 * PKT_LEN));
		// Two spaced packets keep their spacing; access unit fires once
		do_reset(MODE_TSTAMP);
		t0 = cyc;
		enc.send(13'h0007, 1'b0, PKT_LEN, stamp_a);
		au_ts = stamp_a + 32'd50;
		au_load = 1'b1;
		@(negedge mclk);
		au_load = 1'b0;
		repeat (600) @(negedge mclk);
		t1 = cyc;
		enc.send(13'h0007, 1'b0, PKT_LEN, stamp_b);
		repeat (2600) @(negedge mclk);
		check(sop_at.size(), 2);
		check(bytes, 2 * PKT_LEN);
		check(fill, 12'h000);
		check(sop_at[0] - t0 >= 1990 && sop_at[0] - t0 <= 2030, 1'b1);
		gap = (sop_at[1] - sop_at[0]) - (t1 - t0);
		check(gap >= -4 && gap <= 4, 1'b1);
		check(au_n, 1);
		check(au_at - sop_at[0] >= 94 && au_at - sop_at[0] <= 104, 1'b1);
		stop_test();
	end
endmodule
